// ### shared/bscr_pkg.sv
// Constants for the bridge secondary configuration register bank
package bscr_pkg;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFS_BUS_INDEX   = 8'h18;
   localparam logic [7:0]  OFS_IO_STATUS   = 8'h1c;
   localparam logic [7:0]  OFS_PERR_CTRL   = 8'h40;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int          POS_UPSTREAM    = 0;
   localparam int          POS_DOWNSTREAM  = 8;
   localparam int          POS_HIGHEST     = 16;
   localparam int          POS_LATENCY     = 24;
   localparam int          POS_IO_BASE_RO  = 0;
   localparam int          POS_IO_BASE     = 4;
   localparam int          POS_IO_LIM_RO   = 8;
   localparam int          POS_IO_LIMIT    = 12;
   localparam int          POS_CAP66       = 21;
   localparam int          POS_FAST_B2B    = 23;
   localparam int          POS_MDPE        = 24;
   localparam int          POS_SEL_TIMING  = 25;
   localparam int          POS_STA         = 27;
   localparam int          POS_RTA         = 28;
   localparam int          POS_RMA         = 29;
   localparam int          POS_RSE         = 30;
   localparam int          POS_DPE         = 31;
   localparam int          POS_PERR_EN     = 0;

   // ----------------------------------------------------------------
   // Reset and fixed values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_BUS_INDEX   = 8'h00;
   localparam logic [7:0]  RST_LAT_PCI     = 8'h00;
   localparam logic [7:0]  RST_LAT_PCIX    = 8'h40;
   localparam logic [3:0]  RST_IO_NIBBLE   = 4'h0;
   localparam logic [1:0]  IO_ADDR32       = 2'h1;
   localparam logic [1:0]  SEL_MEDIUM      = 2'h1;
   localparam logic [1:0]  SEL_NONE        = 2'h0;
endpackage

// ### src/bscr_regs.sv
// Bridge secondary configuration register bank: bus numbers, I/O window, secondary status
// Behaviour
// - Forward: latency timer writable, mode reset value
// - Reverse: latency timer read-only zero
// - I/O addressing bits read 01, next zero
// - Writable I/O base nibble, reset zero
// - Writable I/O limit nibble, reset zero
// - 66 MHz bit one forward, zero reverse
// - Forward: fast back-to-back follows PCI mode
// - Reverse: fast back-to-back reads zero
// - Parity flag sets only with response enabled
// - Forward: read data parity error sets flag
// - Forward: parity pin during write sets flag
// - Forward: split completion parity message sets flag
// - Reverse: poisoned completion or request sets flag
// - Select timing 01 forward, 00 reverse
// - Forward: target abort sets signaled abort
// - Reverse: completer abort sets signaled abort
//
// Decided for this implementation: the address-and-strobe port.
module bscr_regs (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Configuration straps
   input  wire logic        reverse_mode,
   input  wire logic        pcix_mode,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   // Forward-bridge secondary events
   input  wire logic        fwd_read_parity_err,
   input  wire logic        downstream_parity_error_n,
   input  wire logic        fwd_write_in_progress,
   input  wire logic        fwd_split_parity_msg,
   input  wire logic        fwd_target_abort,
   // Reverse-bridge secondary events
   input  wire logic        rev_poisoned_cpl,
   input  wire logic        rev_poisoned_req,
   input  wire logic        rev_completer_abort,
   // Further secondary error events
   input  wire logic        rx_target_abort,
   input  wire logic        rx_master_abort,
   input  wire logic        rx_system_error,
   input  wire logic        parity_detected,
   // Mode and control view
   output logic             perr_enable,
   output logic      [7:0]  latency_timer
);

   // ----------------------------------------------------------------
   // Mode capture
   // ----------------------------------------------------------------
   logic       init_done_reg;
   logic       reverse_reg;
   logic       pcix_reg;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         init_done_reg <= 1'b0;
         reverse_reg   <= 1'b0;
         pcix_reg      <= 1'b0;
      end else if (!init_done_reg) begin
         init_done_reg <= 1'b1;
         reverse_reg   <= reverse_mode;
         pcix_reg      <= pcix_mode;
      end
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic wr_bus;
   logic wr_io;
   logic wr_ctrl;

   assign wr_bus  = reg_write && (reg_addr == bscr_pkg::OFS_BUS_INDEX);
   assign wr_io   = reg_write && (reg_addr == bscr_pkg::OFS_IO_STATUS);
   assign wr_ctrl = reg_write && (reg_addr == bscr_pkg::OFS_PERR_CTRL);

   // ----------------------------------------------------------------
   // Bus numbers
   // ----------------------------------------------------------------
   logic [7:0] upstream_bus_index_reg;
   logic [7:0] downstream_bus_index_reg;
   logic [7:0] highest_bus_index_reg;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         upstream_bus_index_reg   <= bscr_pkg::RST_BUS_INDEX;
         downstream_bus_index_reg <= bscr_pkg::RST_BUS_INDEX;
         highest_bus_index_reg    <= bscr_pkg::RST_BUS_INDEX;
      end else if (wr_bus) begin
         upstream_bus_index_reg   <= reg_wdata[bscr_pkg::POS_UPSTREAM +: 8];
         downstream_bus_index_reg <= reg_wdata[bscr_pkg::POS_DOWNSTREAM +: 8];
         highest_bus_index_reg    <= reg_wdata[bscr_pkg::POS_HIGHEST +: 8];
      end
   end

   // ----------------------------------------------------------------
   // Latency timer
   // ----------------------------------------------------------------
   logic [7:0] lat_reg;

   // Reloaded once the straps are known so the reset value follows the mode
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lat_reg <= bscr_pkg::RST_LAT_PCI;
      end else if (!init_done_reg) begin
         lat_reg <= (!reverse_mode && pcix_mode) ? bscr_pkg::RST_LAT_PCIX : bscr_pkg::RST_LAT_PCI;
      end else if (reverse_reg) begin
         lat_reg <= bscr_pkg::RST_LAT_PCI;
      end else if (wr_bus) begin
         lat_reg <= reg_wdata[bscr_pkg::POS_LATENCY +: 8];
      end
   end

   // ----------------------------------------------------------------
   // I/O window
   // ----------------------------------------------------------------
   logic [3:0] io_base_reg;
   logic [3:0] io_limit_reg;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         io_base_reg <= bscr_pkg::RST_IO_NIBBLE;
      end else if (wr_io) begin
         io_base_reg <= reg_wdata[bscr_pkg::POS_IO_BASE +: 4];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         io_limit_reg <= bscr_pkg::RST_IO_NIBBLE;
      end else if (wr_io) begin
         io_limit_reg <= reg_wdata[bscr_pkg::POS_IO_LIMIT +: 4];
      end
   end

   // ----------------------------------------------------------------
   // Parity response control
   // ----------------------------------------------------------------
   logic perr_en_reg;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         perr_en_reg <= 1'b0;
      end else if (wr_ctrl) begin
         perr_en_reg <= reg_wdata[bscr_pkg::POS_PERR_EN];
      end
   end

   // ----------------------------------------------------------------
   // Error flags
   // ----------------------------------------------------------------
   logic fwd;
   logic mdpe_event;
   logic sta_event;
   logic mdpe_reg;
   logic sta_reg;
   logic rta_reg;
   logic rma_reg;
   logic rse_reg;
   logic dpe_reg;
   logic [4:0] w1c;

   assign fwd = init_done_reg && !reverse_reg;
   assign w1c = wr_io ? reg_wdata[bscr_pkg::POS_DPE:bscr_pkg::POS_STA] : 5'h00;

   assign mdpe_event = perr_en_reg && init_done_reg &&
                       (reverse_reg ? (rev_poisoned_cpl || rev_poisoned_req)
                                    : (fwd_read_parity_err ||
                                       (!downstream_parity_error_n && fwd_write_in_progress) ||
                                       fwd_split_parity_msg));

   assign sta_event = init_done_reg && (reverse_reg ? rev_completer_abort : fwd_target_abort);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mdpe_reg <= 1'b0;
      end else begin
         mdpe_reg <= mdpe_event || (mdpe_reg && !(wr_io && reg_wdata[bscr_pkg::POS_MDPE]));
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sta_reg <= 1'b0;
         rta_reg <= 1'b0;
         rma_reg <= 1'b0;
         rse_reg <= 1'b0;
         dpe_reg <= 1'b0;
      end else begin
         sta_reg <= sta_event || (sta_reg && !w1c[0]);
         rta_reg <= (init_done_reg && rx_target_abort) || (rta_reg && !w1c[1]);
         rma_reg <= (init_done_reg && rx_master_abort) || (rma_reg && !w1c[2]);
         rse_reg <= (init_done_reg && rx_system_error) || (rse_reg && !w1c[3]);
         dpe_reg <= (init_done_reg && parity_detected) || (dpe_reg && !w1c[4]);
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (reg_addr)
         bscr_pkg::OFS_BUS_INDEX: begin
            rd_mux[bscr_pkg::POS_UPSTREAM +: 8]   = upstream_bus_index_reg;
            rd_mux[bscr_pkg::POS_DOWNSTREAM +: 8] = downstream_bus_index_reg;
            rd_mux[bscr_pkg::POS_HIGHEST +: 8]    = highest_bus_index_reg;
            rd_mux[bscr_pkg::POS_LATENCY +: 8]    = lat_reg;
         end
         bscr_pkg::OFS_IO_STATUS: begin
            rd_mux[bscr_pkg::POS_IO_BASE_RO +: 2] = bscr_pkg::IO_ADDR32;
            rd_mux[bscr_pkg::POS_IO_BASE +: 4]    = io_base_reg;
            rd_mux[bscr_pkg::POS_IO_LIM_RO +: 2]  = bscr_pkg::IO_ADDR32;
            rd_mux[bscr_pkg::POS_IO_LIMIT +: 4]   = io_limit_reg;
            rd_mux[bscr_pkg::POS_CAP66]           = fwd;
            rd_mux[bscr_pkg::POS_FAST_B2B]        = fwd && !pcix_reg;
            rd_mux[bscr_pkg::POS_MDPE]            = mdpe_reg;
            rd_mux[bscr_pkg::POS_SEL_TIMING +: 2] = fwd ? bscr_pkg::SEL_MEDIUM : bscr_pkg::SEL_NONE;
            rd_mux[bscr_pkg::POS_STA]             = sta_reg;
            rd_mux[bscr_pkg::POS_RTA]             = rta_reg;
            rd_mux[bscr_pkg::POS_RMA]             = rma_reg;
            rd_mux[bscr_pkg::POS_RSE]             = rse_reg;
            rd_mux[bscr_pkg::POS_DPE]             = dpe_reg;
         end
         bscr_pkg::OFS_PERR_CTRL: begin
            rd_mux[bscr_pkg::POS_PERR_EN]         = perr_en_reg;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // Data stand only in the cycle after the strobe; zero otherwise
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_read ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         perr_enable   <= 1'b0;
         latency_timer <= 8'h00;
      end else begin
         perr_enable   <= perr_en_reg;
         latency_timer <= lat_reg;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_clear_write;
      wr_io && reg_wdata[bscr_pkg::POS_MDPE];
   endsequence

   property p_lat_reverse;
      @(posedge core_clk) disable iff (!reset_n)
      (init_done_reg && reverse_reg) |=> (lat_reg == 8'h00);
   endproperty
   a_lat_reverse: assert property (p_lat_reverse) else $error("latency timer not zero in reverse");

   property p_lat_write;
      @(posedge core_clk) disable iff (!reset_n)
      (fwd && wr_bus) |=> (lat_reg == $past(reg_wdata[31:24]));
   endproperty
   a_lat_write: assert property (p_lat_write) else $error("latency timer write lost");

   property p_lat_reset;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(init_done_reg) |-> (lat_reg == ((!reverse_reg && pcix_reg) ? 8'h40 : 8'h00));
   endproperty
   a_lat_reset: assert property (p_lat_reset) else $error("latency reset value wrong");

   property p_mdpe_gate;
      @(posedge core_clk) disable iff (!reset_n)
      (!perr_en_reg && !mdpe_reg) |=> !mdpe_reg;
   endproperty
   a_mdpe_gate: assert property (p_mdpe_gate) else $error("parity flag set while disabled");

   property p_mdpe_fwd_pin;
      @(posedge core_clk) disable iff (!reset_n)
      (fwd && perr_en_reg && !downstream_parity_error_n && fwd_write_in_progress) |=> mdpe_reg;
   endproperty
   a_mdpe_fwd_pin: assert property (p_mdpe_fwd_pin) else $error("parity pin event missed");

   property p_mdpe_rev;
      @(posedge core_clk) disable iff (!reset_n)
      (init_done_reg && reverse_reg && perr_en_reg && rev_poisoned_cpl) |=> mdpe_reg;
   endproperty
   a_mdpe_rev: assert property (p_mdpe_rev) else $error("poisoned completion missed");

   property p_mdpe_clear;
      @(posedge core_clk) disable iff (!reset_n)
      (s_clear_write and !mdpe_event) |=> !mdpe_reg;
   endproperty
   a_mdpe_clear: assert property (p_mdpe_clear) else $error("write one did not clear");

   property p_sta_fwd;
      @(posedge core_clk) disable iff (!reset_n)
      (fwd && fwd_target_abort) |=> sta_reg [*1] ##0 (sta_reg || $past(w1c[0]));
   endproperty
   a_sta_fwd: assert property (p_sta_fwd) else $error("target abort flag missed");

   property p_sta_rev;
      @(posedge core_clk) disable iff (!reset_n)
      (init_done_reg && reverse_reg && rev_completer_abort) |=> sta_reg;
   endproperty
   a_sta_rev: assert property (p_sta_rev) else $error("completer abort flag missed");

   property p_rd_status;
      @(posedge core_clk) disable iff (!reset_n)
      (reg_read && reg_addr == bscr_pkg::OFS_IO_STATUS && init_done_reg) |=>
         (reg_rdata[1:0] == 2'h1 && reg_rdata[9:8] == 2'h1 && reg_rdata[21] == !reverse_reg &&
          reg_rdata[26:25] == (reverse_reg ? 2'h0 : 2'h1) && reg_rdata[23] == (!reverse_reg && !pcix_reg));
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("fixed status bits wrong");

   property p_io_fixed;
      @(posedge core_clk) disable iff (!reset_n)
      (reg_read && reg_addr == bscr_pkg::OFS_IO_STATUS) |=> (reg_rdata[3:2] == 2'h0 && reg_rdata[11:10] == 2'h0);
   endproperty
   a_io_fixed: assert property (p_io_fixed) else $error("reserved I/O bits not zero");

   property p_io_base;
      @(posedge core_clk) disable iff (!reset_n)
      wr_io |=> (io_base_reg == $past(reg_wdata[7:4]));
   endproperty
   a_io_base: assert property (p_io_base) else $error("I/O base write lost");

   property p_io_limit;
      @(posedge core_clk) disable iff (!reset_n)
      wr_io |=> (io_limit_reg == $past(reg_wdata[15:12]));
   endproperty
   a_io_limit: assert property (p_io_limit) else $error("I/O limit write lost");

   property p_mdpe_fwd_read;
      @(posedge core_clk) disable iff (!reset_n)
      (fwd && perr_en_reg && fwd_read_parity_err) |=> mdpe_reg;
   endproperty
   a_mdpe_fwd_read: assert property (p_mdpe_fwd_read) else $error("read parity event missed");

   property p_mdpe_fwd_split;
      @(posedge core_clk) disable iff (!reset_n)
      (fwd && perr_en_reg && fwd_split_parity_msg) |=> mdpe_reg;
   endproperty
   a_mdpe_fwd_split: assert property (p_mdpe_fwd_split) else $error("split parity message missed");

   property p_bus_write;
      @(posedge core_clk) disable iff (!reset_n)
      wr_bus |=> (upstream_bus_index_reg == $past(reg_wdata[7:0]) &&
                  downstream_bus_index_reg == $past(reg_wdata[15:8]) && highest_bus_index_reg == $past(reg_wdata[23:16]));
   endproperty
   a_bus_write: assert property (p_bus_write) else $error("bus number write lost");

endmodule

// ### tb/bscr_agent_model.sv
// Secondary bus agent model that raises one-cycle error events toward the register bank
module bscr_agent_model (
   // Clock
   input  wire logic core_clk,
   // Forward-bridge events
   output logic      fwd_read_parity_err,
   output logic      downstream_parity_error_n,
   output logic      fwd_write_in_progress,
   output logic      fwd_split_parity_msg,
   output logic      fwd_target_abort,
   // Reverse-bridge events
   output logic      rev_poisoned_cpl,
   output logic      rev_poisoned_req,
   output logic      rev_completer_abort,
   // Events in either mode
   output logic      rx_target_abort,
   output logic      rx_master_abort,
   output logic      rx_system_error,
   output logic      parity_detected
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [11:0] ev_reg;

   initial ev_reg = 12'h000;

   assign fwd_read_parity_err   = ev_reg[0];
   assign fwd_write_in_progress = ev_reg[1];
   // Pulled up on the board, so a released line reads high
   assign downstream_parity_error_n = ~(ev_reg[1] | ev_reg[11]);
   assign fwd_split_parity_msg  = ev_reg[2];
   assign fwd_target_abort      = ev_reg[3];
   assign rev_poisoned_cpl      = ev_reg[4];
   assign rev_poisoned_req      = ev_reg[5];
   assign rev_completer_abort   = ev_reg[6];
   assign rx_target_abort       = ev_reg[7];
   assign rx_master_abort       = ev_reg[8];
   assign rx_system_error       = ev_reg[9];
   assign parity_detected       = ev_reg[10];

   // One event for one clock; code 11 drops the parity line with no write under way
   task automatic fire(input int code);
      @(posedge core_clk);
      ev_reg <= 12'h001 << code;
      @(posedge core_clk);
      ev_reg <= 12'h000;
   endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the bridge secondary configuration register bank
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        reverse_mode = 1'b0;
   logic        pcix_mode = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic        perr_enable;
   logic [7:0]  latency_timer;
   wire  [11:0] ev;
   int          error_cnt = 0;
   int          cmp_count = 0;

   always #5 core_clk = ~core_clk;

   bscr_regs u_bscr_regs (
      .core_clk(core_clk), .reset_n(reset_n), .reverse_mode(reverse_mode), .pcix_mode(pcix_mode),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .fwd_read_parity_err(ev[0]), .downstream_parity_error_n(ev[11]),
      .fwd_write_in_progress(ev[1]), .fwd_split_parity_msg(ev[2]), .fwd_target_abort(ev[3]),
      .rev_poisoned_cpl(ev[4]), .rev_poisoned_req(ev[5]), .rev_completer_abort(ev[6]),
      .rx_target_abort(ev[7]), .rx_master_abort(ev[8]), .rx_system_error(ev[9]),
      .parity_detected(ev[10]), .perr_enable(perr_enable), .latency_timer(latency_timer));

   bscr_agent_model u_bscr_agent_model (
      .core_clk(core_clk), .fwd_read_parity_err(ev[0]), .downstream_parity_error_n(ev[11]),
      .fwd_write_in_progress(ev[1]), .fwd_split_parity_msg(ev[2]), .fwd_target_abort(ev[3]),
      .rev_poisoned_cpl(ev[4]), .rev_poisoned_req(ev[5]), .rev_completer_abort(ev[6]),
      .rx_target_abort(ev[7]), .rx_master_abort(ev[8]), .rx_system_error(ev[9]),
      .parity_detected(ev[10]));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic summarize();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask

   // Straps are held steady across the release so the capture edge sees them
   task automatic do_reset(input logic rev, input logic pcix);
      @(posedge core_clk);
      reset_n      <= 1'b0;
      reverse_mode <= rev;
      pcix_mode    <= pcix;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      @(posedge core_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp, msg);
   endtask

   // Event sets one flag, a zero write keeps it, a one write clears it
   task automatic flag_cycle(input int code, input int pos, input logic [31:0] base);
      u_bscr_agent_model.fire(code);
      rd_chk(bscr_pkg::OFS_IO_STATUS, base | (32'h1 << pos), "flag set");
      wr(bscr_pkg::OFS_IO_STATUS, 32'h0);
      rd_chk(bscr_pkg::OFS_IO_STATUS, base | (32'h1 << pos), "flag kept on zero write");
      wr(bscr_pkg::OFS_IO_STATUS, 32'h1 << pos);
      rd_chk(bscr_pkg::OFS_IO_STATUS, base, "flag cleared by one");
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_fwd_pcix();
      do_reset(1'b0, 1'b1);
      rd_chk(bscr_pkg::OFS_BUS_INDEX, 32'h40000000, "fwd pcix bus word reset");
      chk({24'h0, latency_timer}, 32'h40, "latency output reset");
      rd_chk(bscr_pkg::OFS_IO_STATUS, 32'h02200101, "fwd pcix status reset");
      wr(bscr_pkg::OFS_BUS_INDEX, 32'h12345678);
      rd_chk(bscr_pkg::OFS_BUS_INDEX, 32'h12345678, "bus bytes written");
      chk({24'h0, latency_timer}, 32'h12, "latency output written");
      wr(bscr_pkg::OFS_IO_STATUS, 32'hffffffff);
      rd_chk(bscr_pkg::OFS_IO_STATUS, 32'h0220f1f1, "io nibbles and fixed bits");
      rd_chk(8'h04, 32'h0, "unmapped read");
   endtask

   task automatic t_fwd_pci();
      do_reset(1'b0, 1'b0);
      rd_chk(bscr_pkg::OFS_BUS_INDEX, 32'h0, "fwd pci bus word reset");
      rd_chk(bscr_pkg::OFS_IO_STATUS, 32'h02a00101, "fwd pci status reset");
      wr(bscr_pkg::OFS_BUS_INDEX, 32'hab000000);
      rd_chk(bscr_pkg::OFS_BUS_INDEX, 32'hab000000, "fwd pci latency written");
   endtask

   task automatic t_reverse();
      do_reset(1'b1, 1'b1);
      rd_chk(bscr_pkg::OFS_BUS_INDEX, 32'h0, "rev bus word reset");
      wr(bscr_pkg::OFS_BUS_INDEX, 32'hffffffff);
      rd_chk(bscr_pkg::OFS_BUS_INDEX, 32'h00ffffff, "rev latency read-only");
      rd_chk(bscr_pkg::OFS_IO_STATUS, 32'h00000101, "rev status reset");
      // Straps moving after capture must not change the mode
      @(posedge core_clk);
      reverse_mode <= 1'b0;
      pcix_mode    <= 1'b0;
      rd_chk(bscr_pkg::OFS_IO_STATUS, 32'h00000101, "straps ignored after capture");
   endtask

   task automatic t_fwd_flags();
      int codes[8] = '{0, 1, 2, 3, 7, 8, 9, 10};
      int bits[8]  = '{24, 24, 24, 27, 28, 29, 30, 31};
      do_reset(1'b0, 1'b0);
      u_bscr_agent_model.fire(0);
      rd_chk(bscr_pkg::OFS_IO_STATUS, 32'h02a00101, "parity flag held while disabled");
      wr(bscr_pkg::OFS_PERR_CTRL, 32'h1);
      rd_chk(bscr_pkg::OFS_PERR_CTRL, 32'h1, "parity enable written");
      chk({31'h0, perr_enable}, 32'h1, "parity enable output");
      u_bscr_agent_model.fire(11);
      rd_chk(bscr_pkg::OFS_IO_STATUS, 32'h02a00101, "parity line outside write");
      for (int i = 0; i < 8; i++) begin
         flag_cycle(codes[i], bits[i], 32'h02a00101);
      end
      // Event and clear land in the same cycle: the event wins
      fork
         u_bscr_agent_model.fire(3);
         wr(bscr_pkg::OFS_IO_STATUS, 32'h1 << 27);
      join
      rd_chk(bscr_pkg::OFS_IO_STATUS, 32'h0aa00101, "set wins over clear");
   endtask

   task automatic t_rev_flags();
      int codes[3] = '{4, 5, 6};
      int bits[3]  = '{24, 24, 27};
      do_reset(1'b1, 1'b0);
      u_bscr_agent_model.fire(4);
      rd_chk(bscr_pkg::OFS_IO_STATUS, 32'h00000101, "rev poison while disabled");
      wr(bscr_pkg::OFS_PERR_CTRL, 32'h1);
      for (int i = 0; i < 3; i++) begin
         flag_cycle(codes[i], bits[i], 32'h00000101);
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      t_fwd_pcix();
      t_fwd_pci();
      t_reverse();
      t_fwd_flags();
      t_rev_flags();
      summarize();
   end

   // The whole run needs about two hundred and thirty cycles; this leaves wide margin
   initial begin
      #200000;
      error_cnt++;
      summarize();
   end
endmodule
